// *** hw/flr_pkg.sv ***
// Purpose: shared constants and types for the flash led register bank
// Assumes: byte-wide registers at their native sub-addresses
// Notes:   reset values are packed from the field defaults
package flr_pkg;

  // register sub-addresses
  localparam logic [7:0] ADDR_DESIGN_INFO = 8'h00;
  localparam logic [7:0] ADDR_PIN_CONFIG  = 8'h02;
  localparam logic [7:0] ADDR_CURRENT     = 8'h03;
  localparam logic [7:0] ADDR_OUT_MODE    = 8'h04;
  localparam logic [7:0] ADDR_FAULT       = 8'h05;
  localparam logic [7:0] ADDR_MASK_CUR    = 8'h06;

  // reset values
  localparam logic [7:0] RST_CURRENT      = 8'h73;
  localparam logic [7:0] RST_OUT_MODE     = 8'hA4;
  localparam logic [7:0] RST_MASK_CUR     = 8'h66;
  localparam logic [1:0] RST_PIN_CFG      = 2'h0;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  // field positions
  localparam int FL_CUR_HI   = 7;
  localparam int FL_CUR_LO   = 3;
  localparam int TOR_CUR_HI  = 2;
  localparam int PEAK_HI     = 7;
  localparam int PEAK_LO     = 6;
  localparam int BIT_STROBE_LEVEL_SEL  = 5;
  localparam int BIT_FREQ_FOLDBACK_ALLOW = 4;
  localparam int BIT_OUT_EN  = 3;
  localparam int BIT_STR_SRC = 2;
  localparam int MODE_HI     = 1;
  localparam int NIB_HI      = 7;
  localparam int NIB_LO      = 4;
  localparam int NIB_LO_HI   = 3;
  localparam int CFG_HI      = 7;
  localparam int CFG_LO      = 6;

  // fault register bits
  localparam int FAULT_W = 8;
  localparam int FLT_OVP = 7;
  localparam int FLT_SC  = 6;
  localparam int FLT_OT  = 5;
  localparam int FLT_TO  = 4;
  localparam int FLT_TX1 = 3;
  localparam int FLT_IO2 = 2;
  localparam int FLT_IL  = 1;
  localparam int FLT_DC  = 0;
  localparam logic [7:0] LOCK_MASK = 8'hF0;

  // synchronised pin positions
  localparam int PIN_W      = 11;
  localparam int PIN_EN     = 0;
  localparam int PIN_STROBE = 1;
  localparam int PIN_MASK1  = 2;
  localparam int PIN_MASK2  = 3;
  localparam int PIN_OVP    = 4;
  localparam int PIN_SC     = 5;
  localparam int PIN_OT     = 6;
  localparam int PIN_TO     = 7;
  localparam int PIN_PEAK   = 8;
  localparam int PIN_DC     = 9;
  localparam int PIN_INDICATOR_LED   = 10;

  typedef enum logic [1:0] {
    FLR_MODE_STANDBY = 2'b00,
    FLR_MODE_VOUT    = 2'b01,
    FLR_MODE_ASSIST  = 2'b10,
    FLR_MODE_FLASH   = 2'b11
  } flr_led_mode_t;

  typedef enum logic [1:0] {
    FLR_PIN_HIZ    = 2'b00,
    FLR_PIN_INDICATOR_LED   = 2'b01,
    FLR_PIN_MASK2  = 2'b10,
    FLR_PIN_ANALOG = 2'b11
  } flr_pin_cfg_t;

  typedef enum logic [0:0] {
    FLR_FL_IDLE = 1'b0,
    FLR_FL_FIRE = 1'b1
  } flr_fl_state_t;

endpackage

// *** hw/flr_flag_if.sv ***
// Purpose: carries event strobes and sticky flags between bank and user
// Assumes: one clock domain
// Notes:   rd_clear is a one-cycle pulse
`timescale 1ns/1ps
interface flr_flag_if #(parameter int W = 8);
  logic [W-1:0] set_evt;   // hardware events
  logic         rd_clear;  // clear-on-read pulse
  logic         init;      // register re-init
  logic [W-1:0] flags;     // sticky flags
  modport bank (input set_evt, input rd_clear, input init, output flags);
  modport user (output set_evt, output rd_clear, output init, input flags);
endinterface

// *** hw/flr_flag_bank.sv ***
// Purpose: sticky clear-on-read flag bank
// Assumes: events and clear come from the same clock domain
// Notes:   a set in the clearing cycle survives the clear
`timescale 1ns/1ps
module flr_flag_bank
  import flr_pkg::*;
#(
  parameter int W = FAULT_W
) (
  input wire logic clk,      // system clock
  input wire logic reset_n,  // async reset, active low
  flr_flag_if.bank f         // flag carrier
);

  // set wins over clear so no event is lost on the read edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f.flags <= '0;
    end else if (f.init) begin
      f.flags <= '0;
    end else begin
      f.flags <= (f.flags & ~{W{f.rd_clear}}) | f.set_evt;
    end
  end

  a_set_survives: assert property ( // [R19]
    @(posedge clk) disable iff (!reset_n)
    (f.set_evt != '0) && !f.init
      |=> (f.flags & $past(f.set_evt)) == $past(f.set_evt))
    else $error("event lost against clear");

endmodule

// *** hw/flr_regs.sv ***
// Purpose: control and status register bank of a flash led driver
// Assumes: serial protocol engine gives one-cycle rd/wr strobes on clk
// Notes:   pins and detector inputs are asynchronous and synchronised
//
// Functional notes
// R01 - flash code in bits 7:3, 300 mA plus 50 mA per step, reset 01110
// R02 - software never writes flash codes above 01110; those are reserved
// R03 - torch code in bits 2:0, 25 mA steps, reset 011
// R04 - peak limit field 7:6, 1.75/2.25/2.75 A, reset 10, 11 reserved
// R05 - bit 5 picks edge (0) or level (1) strobe, reset 1
// R06 - bit 4 allows switching foldback to 1.5 MHz, reset off
// R07 - bit 3 turns the output on, reset off
// R08 - software strobe fires flash once output enabled in flash mode
// R09 - hardware strobe fires flash only while strobe pin is active; with edge strobe the code holds the flash until disarmed
// R10 - mode field: standby, 5 V output, assist, flash; reset standby
// R11 - fault bit 7 overvoltage, bit 6 short circuit, reset 0
// R12 - fault bit 5 overtemperature, bit 4 strobe timeout, reset 0
// R13 - fault bit 3 set when mask one active during flash
// R14 - fault bit 2: mask two during flash, or indicator led fault
// R15 - fault bit 1 set when inductor peak limit reached
// R16 - fault bit 0 set when input dc current limit hit
// R17 - upper nibble: mask two foldback current, 100 mA plus 50 mA steps
// R18 - lower nibble: mask one foldback current, same coding, reset 0110
// R19 - every fault flag clears when the fault register is read; a flag whose event is active in the read cycle stays set
// R20 - severe faults keep the driver disabled until flags are cleared
// R21 - pin two config: hi-z, indicator led, mask two, analog input
`timescale 1ns/1ps
module flr_regs
  import flr_pkg::*;
#(
  parameter logic [7:0] DESIGN_ID = 8'h5A  // arbitrary value
) (
  input  wire logic       clk,                        // 50 MHz clock
  input  wire logic       reset_n,                    // async reset
  input  wire logic [7:0] reg_addr,                   // sub-address
  input  wire logic [7:0] reg_wdata,                  // write byte
  input  wire logic       reg_wr,                     // write strobe
  input  wire logic       reg_rd,                     // read strobe
  input  wire logic       en_pin,                     // enable pin
  input  wire logic       strobe,                     // strobe pin
  input  wire logic       tx_burst_mask_one,          // mask pin one
  input  wire logic       tx_burst_mask_two,          // mask pin two
  input  wire logic       ovp_det,                    // overvoltage
  input  wire logic       sc_det,                     // short circuit
  input  wire logic       ot_det,                     // overtemp
  input  wire logic       timeout_det,                // strobe timeout
  input  wire logic       peak_limit_det,             // peak limit hit
  input  wire logic       dc_limit_det,               // dc limit hit
  input  wire logic       indicator_led_fault_det,             // indicator fault
  output logic      [7:0] reg_rdata,                  // read byte
  output logic      [4:0] flash_current_code,         // flash code
  output logic      [2:0] torch_current_code,         // torch code
  output logic      [1:0] inductor_peak_limit_sel,    // peak limit
  output logic            freq_foldback_allow,        // 1.5 MHz ok
  output logic      [3:0] mask_one_foldback_current,  // mask one code
  output logic      [3:0] mask_two_foldback_current,  // mask two code
  output logic      [1:0] aux_pin_two_config,         // pin two use
  output logic            driver_lockout,             // fault lockout
  output logic            flash_on,                   // flash firing
  output logic            assist_on,                  // assist light
  output logic            vout_on,                    // 5 V output
  output logic            foldback_one_on,            // mask one fold
  output logic            foldback_two_on             // mask two fold
);

  logic [7:0]       current_set;
  logic [7:0]       out_mode;
  logic [7:0]       mask_cur;
  logic [1:0]       pin_cfg;
  logic [PIN_W-1:0] sync_a;
  logic [PIN_W-1:0] sync_b;
  logic             strobe_d;
  logic             en_d;
  logic             en_rise;
  logic             strobe_rise;
  logic             lockout_c;
  logic             armed;
  logic             trigger;
  logic             stop;
  logic             wr_cur;
  logic             wr_mode;
  logic             wr_mask;
  logic             wr_cfg;
  logic [7:0]       next_rdata;
  logic             src_hw;
  logic             str_level;
  flr_led_mode_t    led_drive_mode;
  flr_fl_state_t    fl_state;
  flr_fl_state_t    next_fl_state;

  flr_flag_if #(.W(FAULT_W)) fault_if ();

  flr_flag_bank #(.W(FAULT_W)) u_fault (
    .clk     (clk),
    .reset_n (reset_n),
    .f       (fault_if.bank)
  );

  // two-stage sync; only sync_b feeds logic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {indicator_led_fault_det, dc_limit_det, peak_limit_det,
                 timeout_det, ot_det, sc_det, ovp_det,
                 tx_burst_mask_two, tx_burst_mask_one, strobe, en_pin};
      sync_b <= sync_a;
    end
  end

  // edge history for enable and strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_d     <= 1'b0;
      strobe_d <= 1'b0;
    end else begin
      en_d     <= sync_b[PIN_EN];
      strobe_d <= sync_b[PIN_STROBE];
    end
  end

  assign en_rise     = sync_b[PIN_EN] & ~en_d;
  assign strobe_rise = sync_b[PIN_STROBE] & ~strobe_d;

  // write decode; enable-pin re-init beats a write in the same cycle
  assign wr_cur  = reg_wr && (reg_addr == ADDR_CURRENT) && !en_rise;
  assign wr_mode = reg_wr && (reg_addr == ADDR_OUT_MODE) && !en_rise;
  assign wr_mask = reg_wr && (reg_addr == ADDR_MASK_CUR) && !en_rise;
  assign wr_cfg  = reg_wr && (reg_addr == ADDR_PIN_CONFIG) && !en_rise;

  // current setting register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      current_set <= RST_CURRENT;                   // [R01] [R03]
    end else if (en_rise) begin
      current_set <= RST_CURRENT;
    end else if (wr_cur) begin
      current_set <= reg_wdata;   // reserved codes stored as written
    end
  end

  // output mode register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_mode <= RST_OUT_MODE;                     // [R04] [R05]
    end else if (en_rise) begin
      out_mode <= RST_OUT_MODE;                     // [R06] [R07]
    end else if (wr_mode) begin
      out_mode <= reg_wdata;                        // [R10]
    end
  end

  // mask foldback current register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_cur <= RST_MASK_CUR;                     // [R17] [R18]
    end else if (en_rise) begin
      mask_cur <= RST_MASK_CUR;
    end else if (wr_mask) begin
      mask_cur <= reg_wdata;
    end
  end

  // pin two configuration, other bits of that register not held here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_cfg <= RST_PIN_CFG;                       // [R21]
    end else if (en_rise) begin
      pin_cfg <= RST_PIN_CFG;
    end else if (wr_cfg) begin
      pin_cfg <= reg_wdata[CFG_HI:CFG_LO];
    end
  end

  // field views of the registers
  assign flash_current_code        = current_set[FL_CUR_HI:FL_CUR_LO];
  assign torch_current_code        = current_set[TOR_CUR_HI:0];
  assign inductor_peak_limit_sel   = out_mode[PEAK_HI:PEAK_LO];
  assign freq_foldback_allow       = out_mode[BIT_FREQ_FOLDBACK_ALLOW];
  assign mask_two_foldback_current = mask_cur[NIB_HI:NIB_LO];
  assign mask_one_foldback_current = mask_cur[NIB_LO_HI:0];
  assign aux_pin_two_config        = pin_cfg;
  assign led_drive_mode = flr_led_mode_t'(out_mode[MODE_HI:0]);
  assign src_hw         = out_mode[BIT_STR_SRC];
  assign str_level      = out_mode[BIT_STROBE_LEVEL_SEL];

  // severe faults hold the driver off until read clears them
  assign lockout_c = |(fault_if.flags & LOCK_MASK); // [R20]

  // flash trigger: software fires at once, hardware waits for strobe
  assign armed = out_mode[BIT_OUT_EN] && !lockout_c
                 && (led_drive_mode == FLR_MODE_FLASH);
  always_comb begin
    if (!src_hw) begin
      trigger = 1'b1;                               // [R08]
    end else if (str_level) begin
      trigger = sync_b[PIN_STROBE];                 // [R09]
    end else begin
      trigger = strobe_rise;                        // [R05]
    end
  end
  assign stop = !armed || (src_hw && str_level && !sync_b[PIN_STROBE]);

  // edge mode holds the flash until disarmed; the timer is elsewhere
  always_comb begin
    next_fl_state = fl_state;
    case (fl_state)
      FLR_FL_IDLE: begin
        if (armed && trigger) begin
          next_fl_state = FLR_FL_FIRE;
        end
      end
      FLR_FL_FIRE: begin
        if (stop) begin
          next_fl_state = FLR_FL_IDLE;
        end
      end
      default: begin
        next_fl_state = FLR_FL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fl_state <= FLR_FL_IDLE;
    end else begin
      fl_state <= next_fl_state;
    end
  end

  // registered drive outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_on        <= 1'b0;
      assist_on       <= 1'b0;
      vout_on         <= 1'b0;
      foldback_one_on <= 1'b0;
      foldback_two_on <= 1'b0;
      driver_lockout  <= 1'b0;
    end else begin
      flash_on  <= (next_fl_state == FLR_FL_FIRE);  // [R08] [R09]
      assist_on <= out_mode[BIT_OUT_EN] && !lockout_c
                   && (led_drive_mode == FLR_MODE_ASSIST);  // [R10]
      vout_on   <= out_mode[BIT_OUT_EN] && !lockout_c
                   && (led_drive_mode == FLR_MODE_VOUT);    // [R07]
      foldback_one_on <= (next_fl_state == FLR_FL_FIRE)
                         && sync_b[PIN_MASK1];
      foldback_two_on <= (next_fl_state == FLR_FL_FIRE)
                         && sync_b[PIN_MASK2]
                         && (pin_cfg == FLR_PIN_MASK2);
      driver_lockout  <= lockout_c;                 // [R20]
    end
  end

  // fault events into the sticky bank
  always_comb begin
    fault_if.set_evt          = '0;
    fault_if.set_evt[FLT_OVP] = sync_b[PIN_OVP];    // [R11]
    fault_if.set_evt[FLT_SC]  = sync_b[PIN_SC];     // [R11]
    fault_if.set_evt[FLT_OT]  = sync_b[PIN_OT];     // [R12]
    // timeout only applies with hardware level strobe
    fault_if.set_evt[FLT_TO]  = sync_b[PIN_TO] && src_hw && str_level;  // [R12]
    fault_if.set_evt[FLT_TX1] = (fl_state == FLR_FL_FIRE)
                                && sync_b[PIN_MASK1];  // [R13]
    case (pin_cfg)
      FLR_PIN_MASK2: begin
        fault_if.set_evt[FLT_IO2] = (fl_state == FLR_FL_FIRE)
                                    && sync_b[PIN_MASK2];  // [R14]
      end
      FLR_PIN_INDICATOR_LED: begin
        fault_if.set_evt[FLT_IO2] = sync_b[PIN_INDICATOR_LED];      // [R14]
      end
      default: begin
        fault_if.set_evt[FLT_IO2] = 1'b0;
      end
    endcase
    fault_if.set_evt[FLT_IL]  = sync_b[PIN_PEAK];   // [R15]
    fault_if.set_evt[FLT_DC]  = sync_b[PIN_DC];     // [R16]
  end

  // reading the fault register clears it
  assign fault_if.rd_clear = reg_rd && (reg_addr == ADDR_FAULT);  // [R19]
  assign fault_if.init     = en_rise;

  // read mux; unmapped addresses answer zero
  always_comb begin
    case (reg_addr)
      ADDR_DESIGN_INFO: next_rdata = DESIGN_ID;
      ADDR_PIN_CONFIG:  next_rdata = {pin_cfg, 6'h00};
      ADDR_CURRENT:     next_rdata = current_set;
      ADDR_OUT_MODE:    next_rdata = out_mode;
      ADDR_FAULT:       next_rdata = fault_if.flags;   // [R11] [R12]
      ADDR_MASK_CUR:    next_rdata = mask_cur;
      default:          next_rdata = READ_ZERO;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // checks
  a_cur_write: assert property ( // [R01] [R03]
    @(posedge clk) disable iff (!reset_n)
    wr_cur |=> current_set == $past(reg_wdata))
    else $error("current register write lost");

  a_en_reinit: assert property ( // [R04] [R05] [R06] [R07] [R10]
    @(posedge clk) disable iff (!reset_n)
    en_rise |=> out_mode == RST_OUT_MODE && current_set == RST_CURRENT
                && mask_cur == RST_MASK_CUR && pin_cfg == RST_PIN_CFG)
    else $error("enable edge did not restore defaults");

  a_mask_write: assert property ( // [R17] [R18]
    @(posedge clk) disable iff (!reset_n)
    wr_mask |=> mask_two_foldback_current == $past(reg_wdata[NIB_HI:NIB_LO])
                && mask_one_foldback_current == $past(reg_wdata[NIB_LO_HI:0]))
    else $error("foldback nibbles wrong");

  a_cfg_write: assert property ( // [R21]
    @(posedge clk) disable iff (!reset_n)
    wr_cfg |=> aux_pin_two_config == $past(reg_wdata[CFG_HI:CFG_LO]))
    else $error("pin two config not stored");

  a_sw_fire: assert property ( // [R08]
    @(posedge clk) disable iff (!reset_n)
    armed && !src_hw |=> flash_on)
    else $error("software strobe did not fire");

  a_hw_strobe: assert property ( // [R09]
    @(posedge clk) disable iff (!reset_n)
    src_hw && str_level && !sync_b[PIN_STROBE] |=> !flash_on)
    else $error("flash without strobe");

  a_fault_lock: assert property ( // [R20]
    @(posedge clk) disable iff (!reset_n)
    lockout_c |=> driver_lockout && !flash_on && !assist_on)
    else $error("driver ran during lockout");

  a_read_clear: assert property ( // [R19]
    @(posedge clk) disable iff (!reset_n)
    fault_if.rd_clear && fault_if.set_evt == '0 && !en_rise
      |=> fault_if.flags == '0 ##1 reg_rdata == $past(reg_rdata))
    else $error("fault read did not clear");

  a_fault_read: assert property ( // [R11] [R12]
    @(posedge clk) disable iff (!reset_n)
    fault_if.rd_clear |=> reg_rdata == $past(fault_if.flags))
    else $error("fault read data wrong");

  a_mask_event: assert property ( // [R13]
    @(posedge clk) disable iff (!reset_n)
    fl_state == FLR_FL_FIRE && sync_b[PIN_MASK1] && !en_rise
      |=> fault_if.flags[FLT_TX1])
    else $error("mask one event not flagged");

  a_limit_flags: assert property ( // [R15] [R16]
    @(posedge clk) disable iff (!reset_n)
    (sync_b[PIN_PEAK] || sync_b[PIN_DC]) && !en_rise
      |=> (fault_if.flags[FLT_IL] || !$past(sync_b[PIN_PEAK]))
          && (fault_if.flags[FLT_DC] || !$past(sync_b[PIN_DC])))
    else $error("limit flags not set");

endmodule

// *** tb/flr_host.sv ***
// Purpose: host processor model issuing register strobes
// Assumes: one-cycle strobes on clk, read byte valid one edge later
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ps
module flr_host
  import flr_pkg::*;
(
  input  wire logic       clk,        // system clock
  input  wire logic [7:0] reg_rdata,  // read byte
  output logic      [7:0] reg_addr,   // sub-address
  output logic      [7:0] reg_wdata,  // write byte
  output logic            reg_wr,     // write strobe
  output logic            reg_rd      // read strobe
);
  // quiet bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one write; reserved flash codes are never sent, clamped to the top code
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_CURRENT && v[7:3] > 5'h0E) v[7:3] = 5'h0E;
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
    // one more edge so the stored value has settled before the caller looks
    @(posedge clk);
  endtask

  // one read; byte taken once the sampling edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    // byte stands until the next read, so take it at the following edge
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

// *** tb/flr_regs_tb_top.sv ***
// Purpose: self-checking bench for the flash led register bank
// Assumes: fixed waits follow the sync and answer latencies of the block
// Notes:   det is indexed by the fault bit that each detector sets
`timescale 1ns/1ps
module flr_regs_tb_top
  import flr_pkg::*;
#(
  parameter logic [7:0] ID_VAL = 8'h3C  // arbitrary value
);
  logic       clk, reset_n, en_pin, strobe, mask1, mask2, reg_wr, reg_rd;
  logic [7:0] det, reg_addr, reg_wdata, reg_rdata, rv;
  logic [4:0] fl_code;
  logic [2:0] tor_code;
  logic [1:0] peak_sel, pin_cfg;
  logic [3:0] m1_cur, m2_cur;
  logic       fb_allow, lockout, flash_on, assist_on, vout_on, fold1, fold2;
  int         fails, num_checks;

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  flr_host host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  flr_regs #(.DESIGN_ID(ID_VAL)) dut_u (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .en_pin(en_pin), .strobe(strobe), .tx_burst_mask_one(mask1),
    .tx_burst_mask_two(mask2), .ovp_det(det[7]), .sc_det(det[6]), .ot_det(det[5]),
    .timeout_det(det[4]), .peak_limit_det(det[1]), .dc_limit_det(det[0]),
    .indicator_led_fault_det(det[2]), .reg_rdata(reg_rdata), .flash_current_code(fl_code),
    .torch_current_code(tor_code), .inductor_peak_limit_sel(peak_sel),
    .freq_foldback_allow(fb_allow), .mask_one_foldback_current(m1_cur),
    .mask_two_foldback_current(m2_cur), .aux_pin_two_config(pin_cfg),
    .driver_lockout(lockout), .flash_on(flash_on), .assist_on(assist_on),
    .vout_on(vout_on), .foldback_one_on(fold1), .foldback_two_on(fold2));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, rv);
    chk(rv, exp);
  endtask

  task automatic results;
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // defaults after reset, on the field outputs and by reading back
  task automatic t_reset;
    chk({fl_code, tor_code}, 8'h73);
    chk({peak_sel, 6'h00}, 8'h80);
    chk({fb_allow, lockout, flash_on, assist_on, vout_on, fold1, fold2, 1'b0}, 8'h00);
    chk({m2_cur, m1_cur}, 8'h66);
    rchk(ADDR_OUT_MODE, 8'hA4);
    rchk(ADDR_FAULT, 8'h00);
    rchk(ADDR_DESIGN_INFO, ID_VAL);
  endtask

  // boundary codes, reserved peak code, read-only and unmapped places
  task automatic t_regs;
    host_u.wr(ADDR_CURRENT, 8'h00);
    rchk(ADDR_CURRENT, 8'h00);
    host_u.wr(ADDR_CURRENT, 8'h77);
    chk({fl_code, tor_code}, 8'h77);
    host_u.wr(ADDR_OUT_MODE, 8'hD0);
    rchk(ADDR_OUT_MODE, 8'hD0);
    chk({5'h00, peak_sel, fb_allow}, 8'h07);
    host_u.wr(ADDR_MASK_CUR, 8'h9C);
    chk({m2_cur, m1_cur}, 8'h9C);
    host_u.wr(ADDR_PIN_CONFIG, 8'hFF);
    rchk(ADDR_PIN_CONFIG, 8'hC0);
    chk({6'h00, pin_cfg}, 8'h03);
    host_u.wr(ADDR_FAULT, 8'hFF);
    rchk(ADDR_FAULT, 8'h00);
    rchk(8'h0A, 8'h00);
  endtask

  // enable pin rising edge restores every default
  task automatic t_enable;
    @(posedge clk);
    en_pin <= 1'b0;
    repeat (4) @(posedge clk);
    en_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rchk(ADDR_CURRENT, 8'h73);
    rchk(ADDR_OUT_MODE, 8'hA4);
    rchk(ADDR_MASK_CUR, 8'h66);
    rchk(ADDR_PIN_CONFIG, 8'h00);
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    det[b] <= 1'b1;
    repeat (2) @(posedge clk);
    det[b] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // each detector sets its own flag; a read clears it and lifts the lockout
  task automatic t_faults;
    for (int b = 0; b < 8; b++) begin
      if (b == 2 || b == 3) continue;
      pulse(b);
      chk({7'h00, lockout}, {7'h00, b >= 4});
      rchk(ADDR_FAULT, 8'h01 << b);
      rchk(ADDR_FAULT, 8'h00);
      chk({7'h00, lockout}, 8'h00);
    end
    pulse(2);
    rchk(ADDR_FAULT, 8'h00);
    host_u.wr(ADDR_PIN_CONFIG, 8'h40);
    pulse(2);
    rchk(ADDR_FAULT, 8'h04);
  endtask

  task automatic mask_run(input logic two);
    host_u.wr(ADDR_OUT_MODE, 8'h0B);
    if (two) mask2 <= 1'b1;
    else mask1 <= 1'b1;
    repeat (5) @(posedge clk);
    chk({6'h00, fold2, fold1}, two ? 8'h02 : 8'h01);
    mask1 <= 1'b0;
    mask2 <= 1'b0;
    host_u.wr(ADDR_OUT_MODE, 8'h00);
    rchk(ADDR_FAULT, two ? 8'h04 : 8'h08);
  endtask

  // every mode under software strobe, then masks, level and edge strobe
  task automatic t_flash;
    logic [2:0] e;
    for (int i = 0; i < 4; i++) begin
      e = (i == 3) ? 3'h4 : (i == 2) ? 3'h2 : (i == 1) ? 3'h1 : 3'h0;
      host_u.wr(ADDR_OUT_MODE, {6'h02, i[1:0]});
      repeat (3) @(posedge clk);
      chk({5'h00, flash_on, assist_on, vout_on}, {5'h00, e});
      host_u.wr(ADDR_OUT_MODE, {6'h00, i[1:0]});
      repeat (3) @(posedge clk);
      chk({5'h00, flash_on, assist_on, vout_on}, 8'h00);
    end
    mask_run(1'b0);
    host_u.wr(ADDR_PIN_CONFIG, 8'h80);
    mask_run(1'b1);
    host_u.wr(ADDR_OUT_MODE, 8'hAF);
    repeat (4) @(posedge clk);
    chk({7'h00, flash_on}, 8'h00);
    strobe <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, flash_on}, 8'h01);
    strobe <= 1'b0;
    repeat (4) @(posedge clk);
    chk({7'h00, flash_on}, 8'h00);
    host_u.wr(ADDR_OUT_MODE, 8'h8F);
    strobe <= 1'b1;
    repeat (3) @(posedge clk);
    strobe <= 1'b0;
    repeat (5) @(posedge clk);
    chk({7'h00, flash_on}, 8'h01);
    host_u.wr(ADDR_OUT_MODE, 8'h00);
    repeat (3) @(posedge clk);
    chk({7'h00, flash_on}, 8'h00);
  endtask

  // enable held high through reset, so allow the sync edges before requests
  initial begin
    fails      = 0;
    num_checks = 0;
    reset_n    = 1'b0;
    en_pin     = 1'b1;
    strobe     = 1'b0;
    mask1      = 1'b0;
    mask2      = 1'b0;
    det        = 8'h00;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_regs;
    t_enable;
    t_faults;
    t_flash;
    results;
  end
endmodule
